// file: verilog/pcu_pkg.sv
// pcu_pkg: offsets, field positions, reset values and counts for the
// port control upper fields block.
// assumes a 32-bit apb register bus and a single 20 MHz clock domain.
package pcu_pkg;

	// byte address of the one register on the apb
	localparam logic [11:0] PCU_PORT_CONTROL_ADDR = 12'h000;

	// field positions within port_control, and the feature-support bit of i_pe_features
	localparam int PCU_ERR_CHK_DIS_BIT  = 8;
	localparam int PCU_MCAST_PART_BIT   = 9;
	localparam int PCU_ENUM_BOUND_BIT   = 14;
	localparam int PCU_SUPP_MASK_LSB    = 20;
	localparam int PCU_SUPP_MASK_W      = 8;
	localparam int PCU_PORT_TYPE_BIT    = 31;
	localparam int PCU_FEAT_SUPP_BIT    = 25;

	// values after reset
	localparam logic       PCU_ERR_CHK_DIS_RST = 1'h0;
	// boundary value held until the strap is taken after reset
	localparam logic       PCU_ENUM_BOUND_RST  = 1'h0;
	localparam logic [7:0] PCU_SUPP_MASK_RST   = 8'h00;
	localparam logic       PCU_PORT_TYPE_PAR   = 1'h0;

	// mask of the four low suppression bits, used when crf is not supported
	localparam logic [7:0] PCU_SUPP_LOW_ONLY   = 8'h0f;

	// final settle count; the strap synchroniser output is trusted after four settle cycles (counts 0-3)
	localparam logic [1:0] PCU_STRAP_SETTLE    = 2'h3;

	typedef enum logic [1:0] {
		PCU_ST_SETTLE = 2'b00,
		PCU_ST_LOAD   = 2'b01,
		PCU_ST_RUN    = 2'b10
	} pcu_state_e;

endpackage : pcu_pkg

// file: verilog/pcu_retx_filter.sv
// pcu_retx_filter: decides, for one crc error, whether re-transmission
// is requested or suppressed by the flow class and priority mask.
// assumes the error strobe and its class fields are on i_mclk.
`timescale 1ns/100ps
module pcu_retx_filter
	import pcu_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic [7:0] i_mask,
	input  wire logic       i_chk_on,
	input  wire logic       i_error,
	input  wire logic       i_crf,
	input  wire logic [1:0] i_prio,
	output logic            o_err_report,
	output logic            o_retx_request,
	output logic            o_retx_suppressed
);

	logic next_err_report;
	logic next_retx_request;
	logic next_retx_suppressed;
	logic hit;

	// bits 0-3 are crf=0 priorities 0-3, bits 4-7 crf=1 priorities 0-3
	function automatic logic mask_hit(input logic [7:0] m, input logic crf,
		input logic [1:0] prio);
		logic [2:0] idx;
		idx = {crf, prio};
		mask_hit = m[idx];
	endfunction : mask_hit

	always_comb begin
		hit                  = mask_hit(i_mask, i_crf, i_prio);
		// with checking disabled no error is seen and no recovery runs
		next_err_report      = i_error && i_chk_on;
		next_retx_request    = i_error && i_chk_on && !hit;
		next_retx_suppressed = i_error && i_chk_on && hit;
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_err_report      <= 1'h0;
			o_retx_request    <= 1'h0;
			o_retx_suppressed <= 1'h0;
		end else begin
			o_err_report      <= next_err_report;
			o_retx_request    <= next_retx_request;
			o_retx_suppressed <= next_retx_suppressed;
		end
	end

endmodule : pcu_retx_filter

// file: verilog/pcu_port_control.sv
// pcu_port_control: upper fields of the per-port control register, an apb
// slave, plus the port logic those fields steer.
// assumes an apb master on i_mclk, a boundary strap pin from outside,
// and crc error and multicast-event strobes from the port on i_mclk.
//
// Notes on behaviour
// - bit 8 set turns error checking off
// - participant bit 9 forwards multicast events here
// - boundary reset value comes from system strap
// - bits 20-27 suppress re-transmission, reset zero
// - low nibble crf=0, high nibble crf=1
// - without crf only low nibble is kept
// - mask acts only when feature bit 25 set
// - bit 31 reads zero, parallel port type
// - participant reset value fixed by parameter
`timescale 1ns/100ps
module pcu_port_control
	import pcu_pkg::*;
#(
	parameter logic MCAST_RESET    = 1'h0,
	parameter logic MULTI_PORT     = 1'h1,
	parameter logic CRF_SUPPORTED  = 1'h1,
	parameter logic BOUNDARY_SUPP  = 1'h1
) (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// system configuration
	input  wire logic        i_boundary_strap,
	input  wire logic [31:0] i_pe_features,
	// port events
	input  wire logic        i_crc_error,
	input  wire logic        i_crc_crf,
	input  wire logic [1:0]  i_crc_prio,
	input  wire logic        i_mcast_event,
	// field views and port actions
	output logic             o_err_check_disable,
	output logic             o_mcast_participant,
	output logic             o_enum_boundary,
	output logic      [7:0]  o_suppress_mask,
	output logic             o_port_type,
	output logic             o_mcast_forward,
	output logic             o_err_report,
	output logic             o_retx_request,
	output logic             o_retx_suppressed
);

	// stored fields
	logic       err_chk_dis;
	logic       mcast_part;
	logic       enum_bound;
	logic [7:0] supp_mask;
	logic       next_err_chk_dis;
	logic       next_mcast_part;
	logic       next_enum_bound;
	logic [7:0] next_supp_mask;

	// strap capture
	logic       strap_meta;
	logic       strap_sync;
	logic [1:0] settle_cnt;
	logic [1:0] next_settle_cnt;
	pcu_state_e state;
	pcu_state_e next_state;

	// bus
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic        addr_hit;
	logic        wr_take;
	logic        rd_load;
	logic [31:0] reg_image;
	logic        mcast_fwd;
	logic        next_mcast_fwd;
	logic        feat_supp;
	logic [7:0]  eff_mask;

	// the strap is an asynchronous pin, so it is synchronised before use
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			strap_meta <= 1'h0;
			strap_sync <= 1'h0;
		end else begin
			strap_meta <= i_boundary_strap;
			strap_sync <= strap_meta;
		end
	end

	// settle, then load the strap once; the bus stalls until then so
	// software never reads a boundary bit that is still on its way in
	always_comb begin
		next_state      = state;
		next_settle_cnt = settle_cnt;
		unique case (state)
			PCU_ST_SETTLE: begin
				next_settle_cnt = settle_cnt + 2'h1;
				if (settle_cnt == PCU_STRAP_SETTLE) begin
					next_state = PCU_ST_LOAD;
				end
			end
			PCU_ST_LOAD: begin
				next_state = PCU_ST_RUN;
			end
			PCU_ST_RUN: begin
				next_state = PCU_ST_RUN;
			end
			default: begin
				next_state = PCU_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state      <= PCU_ST_SETTLE;
			settle_cnt <= 2'h0;
		end else begin
			state      <= next_state;
			settle_cnt <= next_settle_cnt;
		end
	end

	assign addr_hit = (i_paddr == PCU_PORT_CONTROL_ADDR);
	assign o_pready = (state == PCU_ST_RUN);
	assign wr_take  = i_psel && i_penable && o_pready && i_pwrite && addr_hit;
	// read data is loaded in setup and while stalled, so it sits in a flop
	assign rd_load  = i_psel && !(i_penable && o_pready);
	// an unmapped address answers with an error, no write and zero data
	assign o_pslverr = i_psel && i_penable && o_pready && !addr_hit;

	// register image: unlisted bits stay zero
	always_comb begin
		reg_image = 32'h0000_0000;
		reg_image[PCU_ERR_CHK_DIS_BIT] = err_chk_dis;
		reg_image[PCU_MCAST_PART_BIT]  = mcast_part;
		reg_image[PCU_ENUM_BOUND_BIT]  = enum_bound;
		reg_image[PCU_SUPP_MASK_LSB +: PCU_SUPP_MASK_W] = supp_mask;
		reg_image[PCU_PORT_TYPE_BIT]   = PCU_PORT_TYPE_PAR;
	end

	always_comb begin
		next_prdata = prdata;
		if (rd_load) begin
			next_prdata = (addr_hit && !i_pwrite) ? reg_image : 32'h0000_0000;
		end
	end

	// field updates; only the defined bits of a write are looked at
	always_comb begin
		next_err_chk_dis = err_chk_dis;
		next_mcast_part  = mcast_part;
		next_enum_bound  = enum_bound;
		next_supp_mask   = supp_mask;
		// strap is taken as the settle count ends, so the load cycle that
		// follows refreshes the read data a stalled read will return
		if (state == PCU_ST_SETTLE && settle_cnt == PCU_STRAP_SETTLE && BOUNDARY_SUPP) begin
			next_enum_bound = strap_sync;
		end
		if (wr_take) begin
			next_err_chk_dis = i_pwdata[PCU_ERR_CHK_DIS_BIT];
			next_mcast_part  = MULTI_PORT && i_pwdata[PCU_MCAST_PART_BIT];
			next_enum_bound  = BOUNDARY_SUPP && i_pwdata[PCU_ENUM_BOUND_BIT];
			next_supp_mask   = i_pwdata[PCU_SUPP_MASK_LSB +: PCU_SUPP_MASK_W];
			if (!CRF_SUPPORTED) begin
				// reserved upper nibble is never stored
				next_supp_mask = next_supp_mask & PCU_SUPP_LOW_ONLY;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			err_chk_dis <= PCU_ERR_CHK_DIS_RST;
			mcast_part  <= MCAST_RESET;
			enum_bound  <= PCU_ENUM_BOUND_RST;
			supp_mask   <= PCU_SUPP_MASK_RST;
			prdata      <= 32'h0000_0000;
		end else begin
			err_chk_dis <= next_err_chk_dis;
			mcast_part  <= next_mcast_part;
			enum_bound  <= next_enum_bound;
			supp_mask   <= next_supp_mask;
			prdata      <= next_prdata;
		end
	end

	assign o_prdata = prdata;

	// mask is inert unless the feature capability says it is supported
	assign feat_supp = i_pe_features[PCU_FEAT_SUPP_BIT];
	assign eff_mask  = feat_supp ? supp_mask : 8'h00;

	// multicast events leave through this port only when it participates
	always_comb begin
		next_mcast_fwd = i_mcast_event && mcast_part && MULTI_PORT;
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			mcast_fwd <= 1'h0;
		end else begin
			mcast_fwd <= next_mcast_fwd;
		end
	end

	pcu_retx_filter u_retx (
		.i_mclk            (i_mclk),
		.i_reset           (i_reset),
		.i_mask            (eff_mask),
		.i_chk_on          (!err_chk_dis),
		.i_error           (i_crc_error),
		.i_crf             (i_crc_crf && CRF_SUPPORTED),
		.i_prio            (i_crc_prio),
		.o_err_report      (o_err_report),
		.o_retx_request    (o_retx_request),
		.o_retx_suppressed (o_retx_suppressed)
	);

	// boundary is only reported; enumeration software honours it
	assign o_err_check_disable = err_chk_dis;
	assign o_mcast_participant = mcast_part;
	assign o_enum_boundary     = enum_bound;
	assign o_suppress_mask     = eff_mask;
	assign o_port_type         = PCU_PORT_TYPE_PAR;
	assign o_mcast_forward     = mcast_fwd;

endmodule : pcu_port_control

// file: test/pcu_port_control_props.sv
// checker for pcu_port_control, bound to every instance.
// assumes default parameters: multi-port, crf supported.
`timescale 1ns/100ps
module pcu_port_control_props (
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic [31:0] i_pe_features,
	input wire logic        o_pready,
	input wire logic        i_crc_error,
	input wire logic        i_crc_crf,
	input wire logic        i_mcast_event,
	input wire logic [1:0]  i_crc_prio,
	input wire logic [7:0]  o_suppress_mask,
	input wire logic        o_err_check_disable,
	input wire logic        o_mcast_participant,
	input wire logic        o_port_type,
	input wire logic        o_mcast_forward,
	input wire logic        o_err_report,
	input wire logic        o_retx_request,
	input wire logic        o_retx_suppressed
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire wr = i_psel & i_penable & i_pwrite & o_pready & (i_paddr == 12'h000);
	wire chk = i_crc_error & !o_err_check_disable;
	AST_ERR_REPORT: assert property (chk |=> o_err_report)
		else $error("crc error not reported");
	AST_ERR_OFF: assert property (i_crc_error & o_err_check_disable
		|=> !(o_err_report | o_retx_request | o_retx_suppressed))
		else $error("unchecked error acted on");
	AST_SUPP: assert property (chk |=> o_retx_request != o_retx_suppressed &&
		o_retx_suppressed == $past(o_suppress_mask[{i_crc_crf, i_crc_prio}]))
		else $error("suppression decision wrong");
	AST_MCAST: assert property (1 |=> o_mcast_forward ==
		$past(i_mcast_event & o_mcast_participant)) else $error("forward wrong");
	AST_GATE: assert property (!i_pe_features[25] |-> o_suppress_mask == 8'h00)
		else $error("mask active without feature");
	AST_TYPE: assert property (!o_port_type && !o_prdata[31])
		else $error("port type not parallel");
	AST_RSVD: assert property ((o_prdata & 32'h700fbc00) == 32'h0)
		else $error("reserved bits not zero");
	AST_WR_BITS: assert property (wr |=> o_err_check_disable == $past(i_pwdata[8]) &&
		o_mcast_participant == $past(i_pwdata[9])) else $error("write lost");
	AST_WR_MASK: assert property (wr ##1 i_pe_features[25] |->
		o_suppress_mask == $past(i_pwdata[27:20])) else $error("mask write lost");
	cover property (wr);
	cover property (chk && o_suppress_mask != 8'h00);
	cover property (o_mcast_forward);
endmodule : pcu_port_control_props
bind pcu_port_control pcu_port_control_props u_props (
	.i_mclk              (i_mclk),
	.i_reset             (i_reset),
	.i_psel              (i_psel),
	.i_penable           (i_penable),
	.i_pwrite            (i_pwrite),
	.i_paddr             (i_paddr),
	.i_pwdata            (i_pwdata),
	.o_prdata            (o_prdata),
	.i_pe_features       (i_pe_features),
	.o_pready            (o_pready),
	.i_crc_error         (i_crc_error),
	.i_crc_crf           (i_crc_crf),
	.i_mcast_event       (i_mcast_event),
	.i_crc_prio          (i_crc_prio),
	.o_suppress_mask     (o_suppress_mask),
	.o_err_check_disable (o_err_check_disable),
	.o_mcast_participant (o_mcast_participant),
	.o_port_type         (o_port_type),
	.o_mcast_forward     (o_mcast_forward),
	.o_err_report        (o_err_report),
	.o_retx_request      (o_retx_request),
	.o_retx_suppressed   (o_retx_suppressed)
);

// file: test/testbench.sv
// testbench: apb register traffic and event strobes, random from a fixed seed.
// assumes pcu_port_control with default parameters.
`timescale 1ns/100ps
module testbench;
	logic        i_mclk = 1'h0, i_reset = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
	logic        i_pwrite = 1'h0, i_boundary_strap = 1'h1, i_crc_error = 1'h0;
	logic        i_crc_crf = 1'h0, i_mcast_event = 1'h0, se;
	logic [1:0]  i_crc_prio = 2'h0;
	logic [11:0] i_paddr = 12'h0;
	logic [31:0] i_pwdata = '0, i_pe_features = '0, o_prdata, rd, d;
	logic        o_pready, o_pslverr, o_err_check_disable, o_mcast_participant;
	logic        o_enum_boundary, o_port_type, o_mcast_forward, o_err_report;
	logic        o_retx_request, o_retx_suppressed;
	logic [7:0]  o_suppress_mask;
	int          num_errors = 0, check_count = 0, cyc = 0;
	pcu_port_control u_dut (
		.i_mclk              (i_mclk),
		.i_reset             (i_reset),
		.i_psel              (i_psel),
		.i_penable           (i_penable),
		.i_pwrite            (i_pwrite),
		.i_paddr             (i_paddr),
		.i_pwdata            (i_pwdata),
		.o_prdata            (o_prdata),
		.o_pready            (o_pready),
		.o_pslverr           (o_pslverr),
		.i_boundary_strap    (i_boundary_strap),
		.i_pe_features       (i_pe_features),
		.i_crc_error         (i_crc_error),
		.i_crc_crf           (i_crc_crf),
		.i_crc_prio          (i_crc_prio),
		.i_mcast_event       (i_mcast_event),
		.o_err_check_disable (o_err_check_disable),
		.o_mcast_participant (o_mcast_participant),
		.o_enum_boundary     (o_enum_boundary),
		.o_suppress_mask     (o_suppress_mask),
		.o_port_type         (o_port_type),
		.o_mcast_forward     (o_mcast_forward),
		.o_err_report        (o_err_report),
		.o_retx_request      (o_retx_request),
		.o_retx_suppressed   (o_retx_suppressed)
	);
	initial forever #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			end_sim();
		end
	end
	function automatic logic [31:0] stored(input logic [31:0] v);
		return v & 32'h0ff04300;
	endfunction : stored
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		check_count++;
		if (g !== ex) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk
	task automatic rst();
		i_reset <= 1'h1;
		repeat (4) @(posedge i_mclk);
		i_reset <= 1'h0;
	endtask : rst
	// waits on pready itself rather than counting the five-cycle settle and load stall after reset
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_mclk);
		i_penable <= 1'h1;
		// pready, read data and error are taken as they stand at the edge
		@(posedge i_mclk);
		while (o_pready !== 1'h1) begin
			@(posedge i_mclk);
		end
		rd = o_prdata;
		se = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask : apb
	task automatic ev(input logic e, input logic m, input logic c, input logic [1:0] p);
		@(posedge i_mclk);
		i_crc_error <= e;
		i_mcast_event <= m;
		i_crc_crf <= c;
		i_crc_prio <= p;
		@(posedge i_mclk);
		i_crc_error <= 1'h0;
		i_mcast_event <= 1'h0;
		#1;
	endtask : ev
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		void'($urandom(32'h0ff2626f));
		rst();
		apb(1'h0, 12'h000, '0);
		chk("reset value", 32'h00004000, rd);
		chk("boundary strap high", 32'h1, 32'(o_enum_boundary));
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? '1 : (i == 1) ? '0 : $urandom;
			i_pe_features <= $urandom;
			apb(1'h1, 12'h000, d);
			apb(1'h0, 12'h000, '0);
			chk("readback", stored(d), rd);
			chk("boundary view", 32'(d[14]), 32'(o_enum_boundary));
			chk("mask view", i_pe_features[25] ? 32'(d[27:20]) : '0, 32'(o_suppress_mask));
			chk("port type", '0, 32'(o_port_type));
		end
		$display("test random done");
		i_pe_features <= 32'h02000000;
		for (int k = 0; k < 16; k++) begin
			d = $urandom;
			d[8] = k[3];
			apb(1'h1, 12'h000, d);
			ev(1'h1, 1'h0, k[2], k[1:0]);
			chk("report", 32'(!k[3]), 32'(o_err_report));
			chk("suppress", 32'(!k[3] && d[20+k[2:0]]), 32'(o_retx_suppressed));
			chk("request", 32'(!k[3] && !d[20+k[2:0]]), 32'(o_retx_request));
		end
		for (int k = 0; k < 2; k++) begin
			apb(1'h1, 12'h000, 32'(k) << 9);
			ev(1'h0, 1'h1, 1'h0, 2'h0);
			chk("forward", k, 32'(o_mcast_forward));
		end
		$display("test events done");
		apb(1'h1, 12'h000, 32'h100);
		apb(1'h1, 12'h004, '0);
		chk("slverr", 32'h1, 32'(se));
		apb(1'h0, 12'h000, '0);
		chk("unmapped write", 32'h100, rd);
		i_boundary_strap <= 1'h0;
		rst();
		apb(1'h0, 12'h000, '0);
		chk("strap low", '0, rd);
		chk("boundary strap low", '0, 32'(o_enum_boundary));
		$display("test boundary done");
		end_sim();
	end
endmodule : testbench
